//--- src/lvr_watchdog_wake_control.sv
`timescale 1ns/1ps
`include "lvr_wdt_defines.svh"
module lvr_watchdog_wake_control (
    // clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       reset_n_in,
    // control register bits
    input  wire lvr_wdt_pkg::misc_ctl_type  misc_ctl_in,
    input  wire logic                       fast_wake_in,
    // power and oscillator status
    input  wire logic                       power_on_done_in,
    input  wire logic                       vdd_below_level_in,
    input  wire logic                       lrc_tick_in,
    input  wire logic                       lrc_enable_in,
    // watchdog control from cpu
    input  wire logic                       wdt_enable_in,
    input  wire logic                       wdt_disable_in,
    input  wire logic                       wdt_clear_in,
    input  wire logic                       osc_calibration_routine_in,
    // power-down requests and wake sources
    input  wire logic                       clock_halt_req_in,
    input  wire logic                       system_stop_req_in,
    input  wire lvr_wdt_pkg::wake_src_type  wake_src_in,
    // outputs
    output logic                            low_voltage_reset_out,
    output logic                            wdt_reset_out,
    output logic                            wdt_running_out,
    output lvr_wdt_pkg::power_state_type    power_state_out,
    output logic                            cpu_run_out
);
    import lvr_wdt_pkg::*;

    logic [19:0]     wdt_count;
    logic [19:0]     wdt_limit;
    logic            wdt_on;
    logic [5:0]      wake_count;
    logic [5:0]      wake_target;
    logic            wake_event;
    logic            lvr_armed;
    power_state_type pstate;

    always_comb begin
        case (misc_ctl_in.wdt_period)
            2'h0:    wdt_limit = `WDT_TIMEOUT_0;
            2'h1:    wdt_limit = `WDT_TIMEOUT_1;
            2'h2:    wdt_limit = `WDT_TIMEOUT_2;
            default: wdt_limit = `WDT_TIMEOUT_3;
        endcase
    end

    // threshold only trusted once supply has settled through power-on
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            lvr_armed <= 1'b0;
        end else if (power_on_done_in) begin
            lvr_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            low_voltage_reset_out <= 1'b0;
        end else begin
            low_voltage_reset_out <= lvr_armed && vdd_below_level_in
                && !misc_ctl_in.lvr_disable
                && (pstate == pd_run);
        end
    end

    // watchdog enable; calibration wins over a same-cycle enable
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wdt_on <= 1'b1;
        end else if (osc_calibration_routine_in || wdt_disable_in) begin
            wdt_on <= 1'b0;
        end else if (wdt_enable_in) begin
            wdt_on <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wdt_count <= 20'h00000;
        end else if (wdt_clear_in || !wdt_on || wdt_reset_out) begin
            wdt_count <= 20'h00000;
        end else if (lrc_enable_in && lrc_tick_in) begin
            wdt_count <= wdt_count + 20'h00001;
        end
    end

    // the pulse masks itself next cycle, so a count held at the limit cannot re-fire
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wdt_reset_out <= 1'b0;
        end else begin
            wdt_reset_out <= wdt_on && !wdt_clear_in && !wdt_reset_out
                && lrc_enable_in && (wdt_count >= wdt_limit - 20'h00001)
                && lrc_tick_in;
        end
    end

    // a stopped oscillator freezes the count, so the watchdog is not live then
    assign wdt_running_out = wdt_on && lrc_enable_in;

    // comparator is a wake source only from clock halt
    always_comb begin
        case (pstate)
            pd_clock_halt:  wake_event = wake_src_in.pin_wake || wake_src_in.timer_wake
                                         || wake_src_in.comparator_wake;
            pd_system_stop: wake_event = wake_src_in.pin_wake;
            default:        wake_event = 1'b0;
        endcase
    end

    assign wake_target = fast_wake_in ? `FAST_WAKE_PERIODS : `SLOW_WAKE_PERIODS;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pstate <= pd_run;
        end else begin
            case (pstate)
                pd_run: begin
                    if (system_stop_req_in) begin
                        pstate <= pd_system_stop;
                    end else if (clock_halt_req_in) begin
                        pstate <= pd_clock_halt;
                    end
                end
                pd_clock_halt,
                pd_system_stop: begin
                    if (wake_event) begin
                        pstate <= pd_waking;
                    end
                end
                pd_waking: begin
                    if (lrc_tick_in && wake_count == wake_target - 6'h01) begin
                        pstate <= pd_run;
                    end
                end
                default: pstate <= pd_run;
            endcase
        end
    end

    // restarts at zero on every entry, so each wake waits the full delay
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_count <= 6'h00;
        end else if (pstate != pd_waking) begin
            wake_count <= 6'h00;
        end else if (lrc_tick_in) begin
            wake_count <= wake_count + 6'h01;
        end
    end

    assign power_state_out = pstate;
    assign cpu_run_out     = (pstate == pd_run);

    // low-voltage reset: waking still counts as power-down, so only run lets it through
    a_lvr_mode_gate: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pstate != pd_run) |=> !low_voltage_reset_out)
        else $error("low-voltage reset during power-down");
    a_lvr_disable: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        misc_ctl_in.lvr_disable |=> !low_voltage_reset_out)
        else $error("low-voltage reset while disabled");
    a_lvr_armed: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !lvr_armed |=> !low_voltage_reset_out)
        else $error("low-voltage reset before power-on done");
    a_lvr_fires: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (lvr_armed && vdd_below_level_in && !misc_ctl_in.lvr_disable && (pstate == pd_run))
        |=> low_voltage_reset_out)
        else $error("low-voltage reset missed");

    // watchdog: one timeout gives exactly one reset pulse and a cleared count
    a_wdt_freeze: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (!lrc_enable_in && !wdt_clear_in && wdt_on && !wdt_reset_out) |=> $stable(wdt_count))
        else $error("watchdog counted with oscillator off");
    a_wdt_count_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (wdt_on && lrc_enable_in && lrc_tick_in && !wdt_clear_in && !wdt_reset_out)
        |=> wdt_count == $past(wdt_count) + 20'h00001)
        else $error("watchdog missed an oscillator tick");
    a_wdt_no_timeout: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !lrc_enable_in |=> !wdt_reset_out)
        else $error("watchdog timeout with oscillator off");
    a_wdt_calib_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        osc_calibration_routine_in |=> !wdt_on ##1 !wdt_reset_out)
        else $error("watchdog still on after calibration");
    a_wdt_enable_on: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (wdt_enable_in && !wdt_disable_in && !osc_calibration_routine_in) |=> wdt_on)
        else $error("watchdog not re-enabled");
    a_wdt_off_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !wdt_on |=> !wdt_reset_out)
        else $error("watchdog reset while disabled");
    a_wdt_reset_cause: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wdt_reset_out |-> $past(wdt_count) >= $past(wdt_limit) - 20'h00001)
        else $error("watchdog reset before timeout");
    a_wdt_timeout_fires: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (wdt_on && lrc_enable_in && lrc_tick_in && !wdt_clear_in && !wdt_reset_out
         && wdt_count == wdt_limit - 20'h00001) |=> wdt_reset_out)
        else $error("watchdog missed selected timeout");
    a_wdt_pulse_once: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        wdt_reset_out |=> !wdt_reset_out && wdt_count == 20'h00000)
        else $error("watchdog reset not a single pulse");

    // wake-up: the delay in force is the one seen on the edge that ends it
    a_stop_no_comp: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pstate == pd_system_stop && !wake_src_in.pin_wake) |=> pstate == pd_system_stop)
        else $error("system stop left without pin wake");
    a_fast_wake_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ($rose(cpu_run_out) && $past(fast_wake_in))
        |-> $past(wake_count) == `FAST_WAKE_PERIODS - 6'h01)
        else $error("fast wake-up length wrong");
    a_slow_wake_len: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ($rose(cpu_run_out) && !$past(fast_wake_in))
        |-> $past(wake_count) == `SLOW_WAKE_PERIODS - 6'h01)
        else $error("normal wake-up length wrong");
endmodule // lvr_watchdog_wake_control

//--- src/lvr_wdt_defines.svh
`ifndef LVR_WDT_DEFINES_SVH
`define LVR_WDT_DEFINES_SVH
// control register bit positions
`define CTL_WDT_PERIOD_LSB      0
`define CTL_WDT_PERIOD_MSB      1
`define CTL_LVR_DISABLE_BIT     2
// watchdog timeouts in low-speed oscillator periods
`define WDT_TIMEOUT_0           20'h02000
`define WDT_TIMEOUT_1           20'h04000
`define WDT_TIMEOUT_2           20'h10000
`define WDT_TIMEOUT_3           20'h40000
// fast wake-up delay in low-speed oscillator periods
`define FAST_WAKE_PERIODS       6'h2D
// normal wake-up delay in low-speed oscillator periods
`define SLOW_WAKE_PERIODS       6'h3F
`endif

//--- src/lvr_wdt_pkg.sv
package lvr_wdt_pkg;
    typedef enum logic [1:0] {
        pd_run,
        pd_clock_halt,
        pd_system_stop,
        pd_waking
    } power_state_type;

    typedef struct packed {
        logic       lvr_disable;
        logic [1:0] wdt_period;
    } misc_ctl_type;

    typedef struct packed {
        logic pin_wake;
        logic timer_wake;
        logic comparator_wake;
    } wake_src_type;
endpackage

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import lvr_wdt_pkg::*;
    logic            clk_in, reset_n_in, fast_wake_in, power_on_done_in, vdd_below_level_in;
    logic            lrc_tick_in, lrc_enable_in, wdt_enable_in, wdt_disable_in, wdt_clear_in;
    logic            osc_calibration_routine_in, clock_halt_req_in, system_stop_req_in;
    misc_ctl_type    misc_ctl_in;
    wake_src_type    wake_src_in;
    logic            low_voltage_reset_out, wdt_reset_out, wdt_running_out, cpu_run_out;
    power_state_type power_state_out;
    int              miscompares = 0, cmp_count = 0, cycles = 0, n, w, i, p, seed;
    logic [31:0]     r;
    logic            rst_seen, slow_tick;
    lvr_watchdog_wake_control lvr_watchdog_wake_control_inst (.clk_in, .reset_n_in,
        .misc_ctl_in, .fast_wake_in, .power_on_done_in, .vdd_below_level_in, .lrc_tick_in,
        .lrc_enable_in, .wdt_enable_in, .wdt_disable_in, .wdt_clear_in,
        .osc_calibration_routine_in, .clock_halt_req_in, .system_stop_req_in, .wake_src_in,
        .low_voltage_reset_out, .wdt_reset_out, .wdt_running_out, .power_state_out,
        .cpu_run_out);
    function automatic logic lvr_expect(input logic armed, dis, below);
        return armed & ~dis & below;
    endfunction
    function automatic int wdt_limit(input logic [1:0] per);
        case (per)
            2'h0:    return 8192;
            2'h1:    return 16384;
            2'h2:    return 65536;
            default: return 262144;
        endcase
    endfunction
    task automatic check(input logic [31:0] seen, exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // counts negedges until the watched flag goes high, bounded
    task automatic wait_high(ref logic flag, input int lim);
        n = 0;
        w = 0;
        while (flag !== 1'b1 && n < lim) begin
            @(negedge clk_in);
            n++;
            // a tick seen while waking is one that the wake-up delay consumes
            if (power_state_out == pd_waking && lrc_tick_in === 1'b1) w++;
        end
    endtask
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    // half-rate ticks make tick counts differ from cycle counts
    always @(posedge clk_in) lrc_tick_in <= !slow_tick || !lrc_tick_in;
    // whole run is about 68k cycles; a hang is cut off at 90k cycles, well above this
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (wdt_reset_out === 1'b1) rst_seen = 1'b1;
        if (cycles == 90000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        seed = 32'h1FEEBB0C;
        {fast_wake_in, power_on_done_in, vdd_below_level_in, wdt_enable_in} = 4'h0;
        {wdt_disable_in, wdt_clear_in, osc_calibration_routine_in} = 3'h0;
        {clock_halt_req_in, system_stop_req_in, reset_n_in} = 3'h0;
        lrc_enable_in = 1'b1;
        slow_tick = 1'b0;
        misc_ctl_in = '0;
        wake_src_in = '0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (i = 0; i < 24; i++) begin
            @(posedge clk_in);
            r = $random(seed);
            power_on_done_in <= (i > 3);
            misc_ctl_in <= '{lvr_disable: r[1], wdt_period: 2'h0};
            vdd_below_level_in <= r[2];
            repeat (2) @(negedge clk_in);
            // the arm flag lands one edge after power-on done, so i == 4 is still unarmed
            check(low_voltage_reset_out, lvr_expect(i > 4, r[1], r[2]), "lvr");
        end
        $display("lvr enable test done");
        @(posedge clk_in);
        misc_ctl_in <= '0;
        vdd_below_level_in <= 1'b1;
        clock_halt_req_in <= 1'b1;
        fast_wake_in <= 1'b1;
        slow_tick <= 1'b1;
        @(posedge clk_in);
        clock_halt_req_in <= 1'b0;
        repeat (2) @(negedge clk_in);
        check(power_state_out, pd_clock_halt, "halt state");
        check(low_voltage_reset_out, 1'b0, "lvr in halt");
        @(posedge clk_in);
        wake_src_in <= '{comparator_wake: 1'b1, default: 1'b0};
        wait_high(cpu_run_out, 300);
        check(w, 45, "fast wake delay");
        @(posedge clk_in);
        wake_src_in <= '0;
        system_stop_req_in <= 1'b1;
        fast_wake_in <= 1'b0;
        @(posedge clk_in);
        system_stop_req_in <= 1'b0;
        wake_src_in <= '{comparator_wake: 1'b1, default: 1'b0};
        repeat (100) @(negedge clk_in);
        check(power_state_out, pd_system_stop, "comparator wake");
        check(low_voltage_reset_out, 1'b0, "lvr in stop");
        @(posedge clk_in);
        wake_src_in <= '{pin_wake: 1'b1, default: 1'b0};
        wait_high(cpu_run_out, 300);
        check(w, 63, "slow wake delay");
        $display("power-down test done");
        @(posedge clk_in);
        wake_src_in <= '0;
        vdd_below_level_in <= 1'b0;
        slow_tick <= 1'b0;
        for (p = 0; p < 4; p++) begin
            misc_ctl_in <= '{lvr_disable: 1'b0, wdt_period: p[1:0]};
            wdt_clear_in <= 1'b1;
            @(posedge clk_in);
            wdt_clear_in <= 1'b0;
            rst_seen = 1'b0;
            if (p < 2) begin
                // one edge more than the timeout: the count starts after the clear
                wait_high(wdt_reset_out, wdt_limit(p[1:0]) + 10);
                check(n, wdt_limit(p[1:0]) + 1, "wdt");
            end else begin
                // long periods too slow to reach: must outlast both short timeouts
                repeat (17000) @(negedge clk_in);
                check(rst_seen, 1'b0, "wdt long period early");
            end
            @(posedge clk_in);
        end
        // oscillator off: counter must freeze well past the shortest timeout
        wdt_clear_in <= 1'b1;
        lrc_enable_in <= 1'b0;
        @(posedge clk_in);
        wdt_clear_in <= 1'b0;
        rst_seen = 1'b0;
        repeat (9000) @(negedge clk_in);
        check(wdt_running_out, 1'b0, "wdt running, osc off");
        check(rst_seen, 1'b0, "wdt fired, osc off");
        @(posedge clk_in);
        lrc_enable_in <= 1'b1;
        osc_calibration_routine_in <= 1'b1;
        @(posedge clk_in);
        osc_calibration_routine_in <= 1'b0;
        repeat (2) @(negedge clk_in);
        check(wdt_running_out, 1'b0, "wdt after calibration");
        @(posedge clk_in);
        wdt_enable_in <= 1'b1;
        @(posedge clk_in);
        wdt_enable_in <= 1'b0;
        repeat (2) @(negedge clk_in);
        check(wdt_running_out, 1'b1, "wdt re-enabled");
        $display("watchdog test done");
        print_verdict();
    end
endmodule // tb_top
